// [design/pwm_pulse_add_generator.sv]
`timescale 1ns/1ps
// What this block does
// (RULE_01) The narrowest pulse is one period of the selected counting clock.
// (RULE_02) A conversion period repeats every 256 counting clock periods.
// (RULE_03) Each period is split into 16 equal basic pulses.
// (RULE_04) The upper duty nibble sets basic pulse duty from 0 to 15/16 in 1/16 steps.
// (RULE_05) The lower nibble picks that many basic pulses for an added pulse, never pulse 0.
// (RULE_06) Values 0 to 4 add none, 15, 7+15, 7+11+15 and 3+7+11+15.
// (RULE_07) Further values add 13, 5, all odd pulses at 8, then 14, 6, 10 and 2.
// (RULE_08) An added pulse is one unit high just before the basic pulse rising edge.
// (RULE_09) With zero upper nibble added pulses still land in the same slots.
// (RULE_10) Pulse k gets an added pulse when the reversal of 15-k is below the lower nibble.
// (RULE_11) Counting stops with enable 0, else runs on the system clock or half rate.
// (RULE_12) Polarity 0 makes duty the high width, polarity 1 inverts the waveform.
// (RULE_13) A pin shows the waveform only with direction and enable both 1.
module pwm_pulse_add_generator (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] modulated_output_pins_in,
  output logic [15:0]      modulated_output_pins_out,
  output logic [15:0]      modulated_output_pins_oe
);

  ////////////////////////////////////////////////////////////////////////
  logic        rst_sync1_reg;
  logic        rst_n_reg;
  logic [7:0]  pwm_duty_value_reg [pwm_pkg::CHANNELS];
  logic [15:0] output_polarity_select_reg;
  logic [15:0] out_enable_reg;
  logic [15:0] direction_reg;
  logic [15:0] port_data_reg;
  logic        modulator_clock_enable_reg;
  logic        modulator_clock_select_reg;
  logic        half_phase_reg;
  logic        tick;
  logic [7:0]  count_reg;
  logic [15:0] wave;
  logic [15:0] pin_sync1_reg;
  logic [15:0] pin_level_reg;
  logic [15:0] pin_out_reg;
  logic        ready_reg;
  logic [31:0] prdata_reg;
  logic        slverr_reg;
  logic        access;
  logic        wr_fire;
  logic        mapped;
  logic [31:0] rd_value;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_n_reg     <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n_reg     <= rst_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so read data comes from a flop
  assign access  = psel & penable;
  assign wr_fire = access & ready_reg & pwrite;
  assign pready  = ready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = slverr_reg;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= pwm_pkg::PIN_LEVEL_ADDR);
  endfunction

  assign mapped = is_mapped(paddr);

  always_comb begin
    rd_value = 32'h0000_0000;
    if (paddr < pwm_pkg::POLARITY_ADDR) begin
      rd_value[7:0] = pwm_duty_value_reg[paddr[5:2]];
    end else begin
      unique case (paddr)
        pwm_pkg::POLARITY_ADDR:   rd_value[15:0] = output_polarity_select_reg;
        pwm_pkg::OUT_ENABLE_ADDR: rd_value[15:0] = out_enable_reg;
        pwm_pkg::DIRECTION_ADDR:  rd_value[15:0] = direction_reg;
        pwm_pkg::PORT_DATA_ADDR:  rd_value[15:0] = port_data_reg;
        pwm_pkg::CLOCK_CTRL_ADDR: rd_value[1:0]  = {modulator_clock_select_reg, modulator_clock_enable_reg};
        pwm_pkg::STATUS_ADDR:     rd_value[7:0]  = count_reg;
        pwm_pkg::PIN_LEVEL_ADDR:  rd_value[15:0] = pin_level_reg;
        default:                  rd_value       = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ready_reg  <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else begin
      ready_reg  <= access & ~ready_reg;
      slverr_reg <= access & ~ready_reg & ~mapped;
      if (access & ~ready_reg & ~pwrite) begin
        prdata_reg <= mapped ? rd_value : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Duty values, one word per channel
  genvar gi;
  generate
    for (gi = 0; gi < pwm_pkg::CHANNELS; gi++) begin : g_duty
      always_ff @(posedge ref_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          pwm_duty_value_reg[gi] <= pwm_pkg::DUTY_RESET;
        end else if (wr_fire && paddr == pwm_pkg::DUTY_BASE_ADDR + 8'(gi * 4)) begin
          pwm_duty_value_reg[gi] <= pwdata[7:0];
        end
      end
      pwm_slice u_slice (
        .count (count_reg),
        .duty  (pwm_duty_value_reg[gi]),
        .wave  (wave[gi])
      );

      // Every channel checked, so the random duties count, not only the marker
      a_last_high: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_04
        pwm_duty_value_reg[gi][7:4] != 4'h0 && count_reg[3:0] == pwm_pkg::SLOT_LAST |-> wave[gi])
        else $error("last slot of a basic pulse low");

      a_first_low: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_08
        pwm_duty_value_reg[gi][7:4] != 4'hf && count_reg[3:0] == 4'h0 |-> !wave[gi])
        else $error("first slot of a basic pulse high");

      a_idle_slots: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_09
        pwm_duty_value_reg[gi][7:4] == 4'h0 && wave[gi] |-> count_reg[3:0] == pwm_pkg::SLOT_LAST)
        else $error("high outside the added slot with zero upper nibble");

      a_quad_row: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_06
        pwm_duty_value_reg[gi] == 8'h04 |-> wave[gi] == (count_reg[5:4] == 2'h3
        && count_reg[3:0] == pwm_pkg::SLOT_LAST))
        else $error("nibble four added pulses misplaced");

      a_odd_row: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_07
        pwm_duty_value_reg[gi] == 8'h08 |-> wave[gi] == (count_reg[4] && count_reg[3:0] == pwm_pkg::SLOT_LAST))
        else $error("nibble eight added pulses misplaced");
    end
  endgenerate

  // Control vectors and clock control
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      output_polarity_select_reg <= pwm_pkg::VEC_RESET;
      out_enable_reg             <= pwm_pkg::VEC_RESET;
      direction_reg              <= pwm_pkg::VEC_RESET;
      port_data_reg              <= pwm_pkg::VEC_RESET;
      modulator_clock_enable_reg <= pwm_pkg::CTRL_RESET[pwm_pkg::CLK_ENABLE_BIT];
      modulator_clock_select_reg <= pwm_pkg::CTRL_RESET[pwm_pkg::CLK_SELECT_BIT];
    end else if (wr_fire) begin
      if (paddr == pwm_pkg::POLARITY_ADDR)   output_polarity_select_reg <= pwdata[15:0];
      if (paddr == pwm_pkg::OUT_ENABLE_ADDR) out_enable_reg             <= pwdata[15:0];
      if (paddr == pwm_pkg::DIRECTION_ADDR)  direction_reg              <= pwdata[15:0];
      if (paddr == pwm_pkg::PORT_DATA_ADDR)  port_data_reg              <= pwdata[15:0];
      if (paddr == pwm_pkg::CLOCK_CTRL_ADDR) begin
        modulator_clock_enable_reg <= pwdata[pwm_pkg::CLK_ENABLE_BIT];
        modulator_clock_select_reg <= pwdata[pwm_pkg::CLK_SELECT_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counting tick; peripheral clock is ref_clk here, so half rate is a toggle
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      half_phase_reg <= 1'b0;
    end else begin
      half_phase_reg <= ~half_phase_reg;
    end
  end

  assign tick = modulator_clock_enable_reg & (~modulator_clock_select_reg | half_phase_reg); // RULE_11

  // One count per resolution unit, wraps every 256
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      count_reg <= pwm_pkg::COUNT_RESET;
    end else if (tick) begin
      count_reg <= count_reg + 8'h01; // RULE_01 RULE_02
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pins; registered so the pin never glitches on slice decoding
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_out_reg <= pwm_pkg::VEC_RESET;
    end else begin
      pin_out_reg <= ((wave ^ output_polarity_select_reg) & out_enable_reg) // RULE_12 RULE_13
                   | (port_data_reg & ~out_enable_reg);
    end
  end

  assign modulated_output_pins_out = pin_out_reg;
  assign modulated_output_pins_oe  = direction_reg; // RULE_13

  // Input pins pass two flops before anyone reads them
  always_ff @(posedge ref_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pin_sync1_reg <= pwm_pkg::VEC_RESET;
      pin_level_reg <= pwm_pkg::VEC_RESET;
    end else begin
      pin_sync1_reg <= modulated_output_pins_in;
      pin_level_reg <= pin_sync1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_tick_at_top;
    tick && count_reg == pwm_pkg::COUNT_LAST;
  endsequence

  sequence s_half_rate_tick;
    modulator_clock_enable_reg && modulator_clock_select_reg && tick;
  endsequence

  a_count_step: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_01
    tick |=> count_reg == $past(count_reg) + 8'h01)
    else $error("count did not advance on tick");

  a_period_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_02
    s_tick_at_top |=> count_reg == pwm_pkg::COUNT_RESET)
    else $error("period did not wrap at 256");

  a_clock_stop: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_11
    !modulator_clock_enable_reg |=> $stable(count_reg))
    else $error("count moved while disabled");

  a_half_rate: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_11
    s_half_rate_tick ##1 modulator_clock_select_reg |-> !tick)
    else $error("half rate ticked twice in a row");

  a_zero_duty: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_04
    pwm_duty_value_reg[0] == 8'h00 |-> !wave[0])
    else $error("zero duty produced a high");

  a_full_basic: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_04
    pwm_duty_value_reg[0] == 8'hf0 |-> wave[0] == (count_reg[3:0] != 4'h0))
    else $error("15/16 basic pulse wrong");

  a_added_last: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_09
    pwm_duty_value_reg[0][7:4] == 4'h0 && pwm_duty_value_reg[0][3:0] != 4'h0
    && count_reg == pwm_pkg::COUNT_LAST |-> wave[0])
    else $error("added pulse missing at pulse 15");

  a_never_pulse0: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_05
    pwm_duty_value_reg[0][7:4] == 4'h0 && count_reg[7:4] == 4'h0 |-> !wave[0])
    else $error("added pulse at pulse 0");

  a_polarity: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_12
    ##1 (((pin_out_reg ^ $past(wave ^ output_polarity_select_reg)) & $past(out_enable_reg)) == 16'h0000))
    else $error("pin level ignores polarity");

  a_port_level: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_13
    ##1 (((pin_out_reg ^ $past(port_data_reg)) & ~$past(out_enable_reg)) == 16'h0000))
    else $error("port output level wrong");

  // Half rate must never skip twice: an idle cycle is followed by a tick
  sequence s_full_rate;
    modulator_clock_enable_reg && !modulator_clock_select_reg;
  endsequence

  sequence s_half_idle;
    modulator_clock_enable_reg && modulator_clock_select_reg && !tick;
  endsequence

  a_full_rate: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_11
    s_full_rate |-> tick)
    else $error("full rate missed a tick");

  a_half_resume: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_11
    s_half_idle ##1 (modulator_clock_enable_reg && modulator_clock_select_reg) |-> tick)
    else $error("half rate skipped two ticks");

  a_tick_gate: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_11
    !modulator_clock_enable_reg |-> !tick)
    else $error("tick while counting is off");

  a_slot_carry: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_03
    tick && count_reg[3:0] == pwm_pkg::SLOT_LAST |=> count_reg[7:4] == $past(count_reg[7:4]) + 4'h1)
    else $error("basic pulse did not advance after 16 slots");

  // Marker channel: one added unit and nothing else in the whole period
  a_one_unit: assert property (@(posedge ref_clk) disable iff (!rst_n_reg) // RULE_08
    pwm_duty_value_reg[0] == 8'h01 |-> wave[0] == (count_reg == pwm_pkg::COUNT_LAST))
    else $error("added pulse not one unit wide");

endmodule

// [design/pwm_pkg.sv]
package pwm_pkg;

  localparam int CHANNELS = 16;
  localparam int DUTY_W   = 8;
  localparam int NIB_W    = 4;

  // Counting clock: 256 resolution units per period, 16 basic pulses
  localparam int          PERIOD_UNITS = 256;
  localparam int          BASIC_PULSES = 16;
  localparam logic [7:0]  COUNT_LAST   = 8'hff;
  localparam logic [3:0]  SLOT_LAST    = 4'hf;

  // Register byte offsets
  localparam logic [7:0] DUTY_BASE_ADDR  = 8'h00;
  localparam logic [7:0] POLARITY_ADDR   = 8'h40;
  localparam logic [7:0] OUT_ENABLE_ADDR = 8'h44;
  localparam logic [7:0] DIRECTION_ADDR  = 8'h48;
  localparam logic [7:0] PORT_DATA_ADDR  = 8'h4c;
  localparam logic [7:0] CLOCK_CTRL_ADDR = 8'h50;
  localparam logic [7:0] STATUS_ADDR     = 8'h54;
  localparam logic [7:0] PIN_LEVEL_ADDR  = 8'h58;

  // Clock control fields
  localparam int CLK_ENABLE_BIT = 0;
  localparam int CLK_SELECT_BIT = 1;

  // Reset values
  localparam logic [7:0]  DUTY_RESET  = 8'h00;
  localparam logic [15:0] VEC_RESET   = 16'h0000;
  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [7:0]  COUNT_RESET = 8'h00;

  // Four-bit reversal of a pulse number's complement
  function automatic logic [3:0] added_rank(input logic [3:0] pulse_no);
    logic [3:0] c;
    c = SLOT_LAST - pulse_no;
    added_rank = {c[0], c[1], c[2], c[3]};
  endfunction

endpackage

// [design/pwm_slice.sv]
`timescale 1ns/1ps
module pwm_slice (
  input  wire logic [7:0] count,
  input  wire logic [7:0] duty,
  output logic            wave
);

  logic [3:0] pulse_no;
  logic [3:0] slot;
  logic [3:0] upper;
  logic [3:0] lower;
  logic       basic_high;
  logic       added_slot;
  logic       pulse_chosen;

  assign pulse_no = count[7:4];
  assign slot     = count[3:0];
  assign upper    = duty[7:4];
  assign lower    = duty[3:0];

  // High over the last 'upper' slots; rising edge at slot 16-upper
  assign basic_high = ({1'b0, slot} + {1'b0, upper}) > {1'b0, pwm_pkg::SLOT_LAST}; // RULE_04 RULE_03

  // One unit just before the rising edge, same slot even with no edge
  assign added_slot = (slot == (pwm_pkg::SLOT_LAST - upper)); // RULE_08 RULE_09

  // Pulse 0 has rank 15, never below a 4-bit lower nibble
  assign pulse_chosen = pwm_pkg::added_rank(pulse_no) < lower; // RULE_05 RULE_06 RULE_07 RULE_10

  assign wave = basic_high | (added_slot & pulse_chosen);

endmodule

// [sim/pin_filter_model.sv]
`timescale 1ns/1ps
module pin_filter_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] drive_level,
  input  wire logic [15:0] drive_en,
  output logic [15:0]      pin_level
);
  logic [15:0] held_reg = 16'h0000;
  // Undriven pins float: toggle so a stale level never looks valid
  always_ff @(posedge ref_clk) begin
    held_reg <= pin_level;
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_level[i] = drive_en[i] ? drive_level[i] : ~held_reg[i];
    end
  end
endmodule

// [sim/pwm_pulse_add_generator_tb_top.sv]
`timescale 1ns/1ps
module pwm_pulse_add_generator_tb_top;
  logic        ref_clk      = 1'b0;
  logic        rstn         = 1'b0;
  logic        psel         = 1'b0;
  logic        penable      = 1'b0;
  logic        pwrite       = 1'b0;
  logic [7:0]  paddr        = 8'h00;
  logic [31:0] pwdata       = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] pin_in;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          seed         = 46;
  logic [33:0] exp_q[$];
  logic [33:0] mon_e;
  logic [7:0]  duty_tab[16];
  logic [15:0] pol;
  logic [15:0] oen;
  logic [15:0] dir;
  logic [15:0] pdat;
  always #20 ref_clk = ~ref_clk;
  pwm_pulse_add_generator uut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .modulated_output_pins_in(pin_in), .modulated_output_pins_out(pin_out),
    .modulated_output_pins_oe(pin_oe));
  pin_filter_model partner (.ref_clk(ref_clk), .drive_level(pin_out), .drive_en(pin_oe),
    .pin_level(pin_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    exp_q.push_back({wr, err, d});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      miscompares++;
      complete_run;
    end
    @(posedge ref_clk);
  endtask
  // Answers are matched in issue order; writes check only the error flag
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        miscompares++;
      end else begin
        mon_e = exp_q.pop_front();
        check(32'(pslverr), 32'(mon_e[32]));
        if (!mon_e[33]) begin
          check(prdata, mon_e[31:0]);
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic ewave(input logic [7:0] c, input logic [7:0] d);
    logic [3:0] k;
    k = 4'hf - c[7:4];
    return ({1'b0, c[3:0]} >= 5'h10 - {1'b0, d[7:4]}) ||
           ({k[0], k[1], k[2], k[3]} < d[3:0] && c[3:0] == 4'hf - d[7:4]);
  endfunction
  // Channel 0 holds duty 01: its lone pulse marks count ff
  task automatic scan(input int step);
    int n;
    logic [7:0] c;
    logic [15:0] e;
    n = 0;
    while (pin_out[0] !== 1'b0 && n < 600) begin @(posedge ref_clk); n++; end
    while (pin_out[0] !== 1'b1 && n < 1200) begin @(posedge ref_clk); n++; end
    if (n >= 1200) begin
      miscompares++;
      complete_run;
    end
    for (int t = 0; t < 512 * step; t++) begin
      c = 8'hff + 8'(t / step);
      for (int i = 0; i < 16; i++) begin
        e[i] = oen[i] ? ewave(c, duty_tab[i]) ^ pol[i] : pdat[i];
      end
      check(32'(pin_out), 32'(e));
      check(32'(pin_oe), 32'(dir));
      @(posedge ref_clk);
    end
  endtask
  task automatic setup(input int r);
    for (int i = 0; i < 16; i++) begin
      duty_tab[i] = 8'($random(seed));
      duty_tab[i][3:0] = (r == 0) ? 4'(i) : 4'(15 - i);
      if (r == 1 && i[0]) duty_tab[i][7:4] = 4'h0;
      if (i == 0) duty_tab[i] = 8'h01;
      apb(1'b1, 8'(4 * i), {24'h0, duty_tab[i]}, 1'b0);
    end
    pol = 16'($random(seed)) & 16'hfffe;
    oen = 16'($random(seed)) | 16'h0001;
    dir = 16'($random(seed)) | 16'h0001;
    pdat = 16'($random(seed));
    apb(1'b1, 8'h40, {16'h0, pol}, 1'b0);
    apb(1'b1, 8'h44, {16'h0, oen}, 1'b0);
    apb(1'b1, 8'h48, {16'h0, dir}, 1'b0);
    apb(1'b1, 8'h4c, {16'h0, pdat}, 1'b0);
    apb(1'b0, 8'h40, {16'h0, pol}, 1'b0);
    apb(1'b0, 8'h3c, {24'h0, duty_tab[15]}, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int a = 'h40; a <= 'h54; a += 4) apb(1'b0, 8'(a), 32'h0, 1'b0);
    apb(1'b1, 8'h60, 32'hffffffff, 1'b1);
    apb(1'b0, 8'h5c, 32'h0, 1'b1);
    apb(1'b0, 8'h02, 32'h0, 1'b1);
    $display("test reset_and_decode done");
    setup(0);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, 8'h54, 32'h0, 1'b0);
    apb(1'b1, 8'h50, 32'h1, 1'b0);
    scan(1);
    $display("test full_rate done");
    setup(1);
    apb(1'b1, 8'h50, 32'h3, 1'b0);
    scan(2);
    $display("test half_rate done");
    apb(1'b1, 8'h00, 32'h0000_00f0, 1'b0);
    apb(1'b0, 8'h00, 32'h0000_00f0, 1'b0);
    repeat (520) @(posedge ref_clk);
    apb(1'b1, 8'h00, 32'h0000_0000, 1'b0);
    for (int t = 0; t < 520; t++) begin
      @(posedge ref_clk);
      check(32'(pin_out[0]), 32'h0000_0000);
    end
    $display("test duty_extremes done");
    oen = 16'h0000;
    apb(1'b1, 8'h44, 32'h0, 1'b0);
    apb(1'b1, 8'h48, 32'hffff, 1'b0);
    repeat (4) @(posedge ref_clk);
    apb(1'b0, 8'h58, {16'h0, pdat}, 1'b0);
    $display("test port_output done");
    complete_run;
  end
endmodule
